// File: ces_params.svh
// Purpose: constants of the exception sequencer
// Assumes: included by bare name
// Notes: definitions only
`ifndef CES_PARAMS_SVH
`define CES_PARAMS_SVH
// status word fields
`define CES_SR_T 15
`define CES_SR_S 13
`define CES_SR_MHI 10
`define CES_SR_MLO 8
`define CES_SR_V 1
`define CES_SR_RST 16'h2700
`define CES_SR_IMPL 16'ha71f
// vector numbers and other constants
`define CES_V_BUSERR 8'h02
`define CES_V_ADDRERR 8'h03
`define CES_V_ILLEGAL 8'h04
`define CES_V_DIVZ 8'h05
`define CES_V_CHK 8'h06
`define CES_V_TRAP_ON_OVERFLOW 8'h07
`define CES_V_PRIV 8'h08
`define CES_V_TRACE 8'h09
`define CES_V_FMTERR 8'h0e
`define CES_V_TRAP0 8'h20
`define CES_IRQ_TOP 3'h7
`define CES_FMT_ZERO 4'h0
`define CES_WSTEP 32'h00000002
`define CES_RESET_OUTPUT_LINE_CYCLES 8'h10
// register offsets
`define CES_A_STATUS 12'h000
`define CES_A_SSP 12'h004
`define CES_A_PC 12'h008
`define CES_A_INFO 12'h00c
`endif

// File: ces_pkg.sv
// Purpose: types of the exception sequencer
// Assumes: nothing
// Notes: constants live in ces_params.svh
package ces_pkg;
  typedef enum logic [3:0] {
    OP_OTHER, OP_RESET, OP_ORSR, OP_HALT, OP_RTE,
    OP_TRAP, OP_TRAP_ON_OVERFLOW, OP_CHK, OP_DIV, OP_ILLEGAL
  } ces_op_t;
  typedef enum logic [2:0] {
    S_RESET_FETCH, S_IDLE, S_CAPTURE, S_IACK,
    S_STACK, S_VFETCH, S_RTE_POP, S_HALTED
  } ces_state_t;
  typedef struct packed {
    ces_op_t op;
    logic [15:0] imm;
    logic [3:0] tnum;
    logic fail;
    logic [31:0] pc;
    logic [31:0] next_pc;
  } ces_insn_t;
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ces_mem_t;
endpackage : ces_pkg

// File: ces_ahb_slv.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers
// Notes: read data latched in the address phase
`timescale 1ns/1ps
`include "ces_params.svh"
module ces_ahb_slv (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register side
  output logic [11:0] rd_off,
  input wire logic [31:0] rd_word,
  output logic wr_go,
  output logic [11:0] wr_off
);
  logic take;
  logic wr_pend_r;
  logic [11:0] wr_off_r;
  logic [31:0] hrdata_r;

  assign take = hsel && hready && htrans[1];
  assign rd_off = haddr[11:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 12'h000;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      wr_off_r <= haddr[11:0];
    end
  end

  // a read right after a write sees the old value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (take && !hwrite)
      hrdata_r <= rd_word;
  end

  assign wr_go = wr_pend_r;
  assign wr_off = wr_off_r;
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : ces_ahb_slv

// File: ces_seq.sv
// Purpose: exception sequencer of a processor core
// Assumes: one clock, inputs synchronous to hclk
// Notes: memory port moves 16-bit words
// What this block does
// - copy the status word before any exception changes it
// - then set supervisor bit and clear trace bit
// - reset and interrupts also update the priority mask
// - interrupts fetch their vector number by an acknowledge cycle
// - other exceptions get their vector number internally
// - every exception but reset pushes a frame; reset pushes nothing
// - the frame goes on the supervisor stack
// - finally load pc from the vector and resume execution
// - nobody may rely on the order of exception bus cycles
// - external and internal causes both start exception processing
// - trap, overflow trap, bounds check, return, divide may raise exceptions
// - illegal opcodes and user-state privileged opcodes raise exceptions
// - reset opcode pulses the reset output only in supervisor state
// - or-immediate to status word only in supervisor state, else trap
// - halt loads immediate into status word then stops unless trace bit set; user state traps
// - return pops status word and pc, then frame; user state traps
// - trap pushes format, pc, status word, then jumps via vector
// - vector address is vector number shifted left two, zero filled
`timescale 1ns/1ps
`include "ces_params.svh"
module ces_seq (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // instruction stream
  input wire logic insn_valid,
  input wire ces_pkg::ces_insn_t insn,
  output logic insn_ready,
  // fault events
  input wire logic bus_err,
  input wire logic addr_err,
  // interrupts
  input wire logic [2:0] irq_level,
  output logic iack_req,
  output logic [2:0] iack_level,
  input wire logic iack_ack,
  input wire logic [7:0] iack_vec,
  // memory port
  output logic mem_req,
  output ces_pkg::ces_mem_t mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // status
  output logic reset_output_line,
  output logic halted,
  output logic [15:0] status_word
);
  ces_pkg::ces_state_t state_r, state_nxt;
  logic [1:0] step_r, step_nxt;
  logic [15:0] sr_r, sr_nxt, sr_copy_r, sr_copy_nxt, tmp_r, tmp_nxt;
  logic [31:0] ssp_r, ssp_nxt, pc_r, pc_nxt, ret_pc_r, ret_pc_nxt;
  logic [7:0] vec_r, vec_nxt, reset_output_line_cnt_r;
  logic irq_r, irq_nxt;
  logic [2:0] lvl_r, lvl_nxt;
  logic exc_go, exc_irq, reset_output_line_go, irq_hit, sup, busy, take;
  logic [7:0] exc_vec;
  logic [31:0] exc_pc, vec_off, rd_word;
  logic [11:0] rd_off, wr_off;
  logic wr_go, reset_output_line_r;

  ces_ahb_slv u_slv (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_off(rd_off),
    .rd_word(rd_word),
    .wr_go(wr_go),
    .wr_off(wr_off)
  );

  assign sup = sr_r[`CES_SR_S];
  assign busy = (state_r != ces_pkg::S_IDLE) && (state_r != ces_pkg::S_HALTED);
  assign irq_hit = (irq_level > sr_r[`CES_SR_MHI:`CES_SR_MLO]) || (irq_level == `CES_IRQ_TOP);
  assign insn_ready = (state_r == ces_pkg::S_IDLE) && !bus_err && !addr_err && !irq_hit;
  assign take = insn_valid && insn_ready;
  assign vec_off = {22'h000000, vec_r, 2'b00};

  always_comb
  begin
    unique case (rd_off)
      `CES_A_STATUS: rd_word = {16'h0000, sr_r};
      `CES_A_SSP: rd_word = ssp_r;
      `CES_A_PC: rd_word = pc_r;
      `CES_A_INFO: rd_word = {16'h0000, vec_r, 4'h0, irq_r, reset_output_line_r, halted, busy};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    step_nxt = step_r;
    sr_nxt = sr_r;
    sr_copy_nxt = sr_copy_r;
    tmp_nxt = tmp_r;
    ssp_nxt = ssp_r;
    pc_nxt = pc_r;
    ret_pc_nxt = ret_pc_r;
    vec_nxt = vec_r;
    irq_nxt = irq_r;
    lvl_nxt = lvl_r;
    exc_go = 1'b0;
    exc_irq = 1'b0;
    exc_vec = vec_r;
    exc_pc = pc_r;
    reset_output_line_go = 1'b0;
    // software may retarget status and stack only while quiet
    if (wr_go && !busy)
    begin
      if (wr_off == `CES_A_STATUS)
        sr_nxt = hwdata[15:0] & `CES_SR_IMPL;
      if (wr_off == `CES_A_SSP)
        ssp_nxt = hwdata;
    end
    unique case (state_r)
      ces_pkg::S_RESET_FETCH:
        if (mem_ack)
        begin
          step_nxt = step_r + 2'h1;
          if (step_r == 2'h0)
            ssp_nxt = {mem_rdata, ssp_r[15:0]};
          if (step_r == 2'h1)
            ssp_nxt = {ssp_r[31:16], mem_rdata};
          if (step_r == 2'h2)
            pc_nxt = {mem_rdata, pc_r[15:0]};
          if (step_r == 2'h3)
          begin
            pc_nxt = {pc_r[31:16], mem_rdata};
            state_nxt = ces_pkg::S_IDLE;
          end
        end
      ces_pkg::S_IDLE, ces_pkg::S_HALTED:
        if (bus_err)
        begin
          exc_go = 1'b1;
          exc_vec = `CES_V_BUSERR;
        end
        else if (addr_err)
        begin
          exc_go = 1'b1;
          exc_vec = `CES_V_ADDRERR;
        end
        else if (irq_hit)
        begin
          exc_go = 1'b1;
          exc_irq = 1'b1;
        end
        else if (take)
        begin
          pc_nxt = insn.next_pc;
          exc_pc = insn.next_pc;
          if (!sup && (insn.op == ces_pkg::OP_RESET || insn.op == ces_pkg::OP_ORSR ||
              insn.op == ces_pkg::OP_HALT || insn.op == ces_pkg::OP_RTE))
          begin
            // nothing architectural moves on a privilege fault
            pc_nxt = pc_r;
            exc_go = 1'b1;
            exc_vec = `CES_V_PRIV;
            exc_pc = insn.pc;
          end
          else
            unique case (insn.op)
              ces_pkg::OP_RESET: reset_output_line_go = 1'b1;
              ces_pkg::OP_ORSR: sr_nxt = (sr_r | insn.imm) & `CES_SR_IMPL;
              ces_pkg::OP_HALT:
              begin
                sr_nxt = insn.imm & `CES_SR_IMPL;
                state_nxt = ces_pkg::S_HALTED;
              end
              ces_pkg::OP_RTE:
              begin
                state_nxt = ces_pkg::S_RTE_POP;
                step_nxt = 2'h0;
              end
              ces_pkg::OP_TRAP:
              begin
                exc_go = 1'b1;
                exc_vec = `CES_V_TRAP0 + {4'h0, insn.tnum};
              end
              ces_pkg::OP_TRAP_ON_OVERFLOW:
              begin
                exc_go = sr_r[`CES_SR_V];
                exc_vec = `CES_V_TRAP_ON_OVERFLOW;
              end
              ces_pkg::OP_CHK:
              begin
                exc_go = insn.fail;
                exc_vec = `CES_V_CHK;
              end
              ces_pkg::OP_DIV:
              begin
                exc_go = insn.fail;
                exc_vec = `CES_V_DIVZ;
              end
              ces_pkg::OP_ILLEGAL:
              begin
                exc_go = 1'b1;
                exc_vec = `CES_V_ILLEGAL;
                exc_pc = insn.pc;
                pc_nxt = pc_r;
              end
              ces_pkg::OP_OTHER: exc_go = 1'b0;
            endcase
          if (!exc_go && sr_r[`CES_SR_T] && insn.op != ces_pkg::OP_RTE)
          begin
            exc_go = 1'b1;
            exc_vec = `CES_V_TRACE;
          end
        end
      ces_pkg::S_CAPTURE:
      begin
        sr_nxt[`CES_SR_S] = 1'b1;
        sr_nxt[`CES_SR_T] = 1'b0;
        step_nxt = 2'h0;
        if (irq_r)
        begin
          sr_nxt[`CES_SR_MHI:`CES_SR_MLO] = lvl_r;
          state_nxt = ces_pkg::S_IACK;
        end
        else
          state_nxt = ces_pkg::S_STACK;
      end
      ces_pkg::S_IACK:
        if (iack_ack)
        begin
          vec_nxt = iack_vec;
          state_nxt = ces_pkg::S_STACK;
        end
      ces_pkg::S_STACK:
        if (mem_ack)
        begin
          ssp_nxt = ssp_r - `CES_WSTEP;
          step_nxt = step_r + 2'h1;
          if (step_r == 2'h3)
            state_nxt = ces_pkg::S_VFETCH;
        end
      ces_pkg::S_VFETCH:
        if (mem_ack)
        begin
          step_nxt = step_r + 2'h1;
          if (step_r == 2'h0)
            pc_nxt = {mem_rdata, pc_r[15:0]};
          else
          begin
            pc_nxt = {pc_r[31:16], mem_rdata};
            state_nxt = ces_pkg::S_IDLE;
          end
        end
      ces_pkg::S_RTE_POP:
        if (mem_ack)
        begin
          ssp_nxt = ssp_r + `CES_WSTEP;
          step_nxt = step_r + 2'h1;
          if (step_r == 2'h0)
            tmp_nxt = mem_rdata;
          if (step_r == 2'h1)
            pc_nxt = {mem_rdata, pc_r[15:0]};
          if (step_r == 2'h2)
            pc_nxt = {pc_r[31:16], mem_rdata};
          if (step_r == 2'h3)
          begin
            sr_nxt = tmp_r & `CES_SR_IMPL;
            state_nxt = ces_pkg::S_IDLE;
            // only the short frame is known; others are refused
            if (mem_rdata[15:12] != `CES_FMT_ZERO)
            begin
              exc_go = 1'b1;
              exc_vec = `CES_V_FMTERR;
              exc_pc = pc_r;
            end
          end
        end
    endcase
    if (exc_go)
    begin
      sr_copy_nxt = sr_nxt;
      vec_nxt = exc_vec;
      ret_pc_nxt = exc_pc;
      irq_nxt = exc_irq;
      lvl_nxt = irq_level;
      state_nxt = ces_pkg::S_CAPTURE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ces_pkg::S_RESET_FETCH;
      step_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      step_r <= step_nxt;
    end
  end

  // reset comes up privileged, untraced, fully masked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sr_r <= `CES_SR_RST;
      sr_copy_r <= `CES_SR_RST;
      tmp_r <= 16'h0000;
    end
    else
    begin
      sr_r <= sr_nxt;
      sr_copy_r <= sr_copy_nxt;
      tmp_r <= tmp_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ssp_r <= 32'h00000000;
      pc_r <= 32'h00000000;
      ret_pc_r <= 32'h00000000;
    end
    else
    begin
      ssp_r <= ssp_nxt;
      pc_r <= pc_nxt;
      ret_pc_r <= ret_pc_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_r <= 8'h00;
      irq_r <= 1'b0;
      lvl_r <= 3'h0;
    end
    else
    begin
      vec_r <= vec_nxt;
      irq_r <= irq_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_output_line_cnt_r <= 8'h00;
      reset_output_line_r <= 1'b0;
    end
    else
    begin
      if (reset_output_line_go)
        reset_output_line_cnt_r <= `CES_RESET_OUTPUT_LINE_CYCLES;
      else if (reset_output_line_cnt_r != 8'h00)
        reset_output_line_cnt_r <= reset_output_line_cnt_r - 8'h01;
      reset_output_line_r <= reset_output_line_go || (reset_output_line_cnt_r > 8'h01);
    end
  end

  assign reset_output_line = reset_output_line_r;
  assign halted = state_r == ces_pkg::S_HALTED;
  assign status_word = sr_r;
  assign iack_req = state_r == ces_pkg::S_IACK;
  assign iack_level = lvl_r;
  // reset fetch never writes, so reset stacks nothing
  assign mem_req = (state_r == ces_pkg::S_RESET_FETCH) || (state_r == ces_pkg::S_STACK) ||
                   (state_r == ces_pkg::S_VFETCH) || (state_r == ces_pkg::S_RTE_POP);

  // one process drives the whole port struct
  always_comb
  begin
    mem.we = state_r == ces_pkg::S_STACK;
    unique case (state_r)
      ces_pkg::S_RESET_FETCH: mem.addr = {21'h000000, step_r, 1'b0};
      ces_pkg::S_STACK: mem.addr = 24'(ssp_r[23:0] - `CES_WSTEP);
      ces_pkg::S_VFETCH: mem.addr = vec_off[23:0] | {22'h000000, step_r[0], 1'b0};
      default: mem.addr = ssp_r[23:0];
    endcase
    unique case (step_r)
      2'h0: mem.wdata = {`CES_FMT_ZERO, 2'b00, vec_r, 2'b00};
      2'h1: mem.wdata = ret_pc_r[15:0];
      2'h2: mem.wdata = ret_pc_r[31:16];
      2'h3: mem.wdata = sr_copy_r;
    endcase
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence enter_exc_s;
    state_r == ces_pkg::S_CAPTURE && $past(state_r) != ces_pkg::S_CAPTURE;
  endsequence
  sequence last_fetch_s;
    state_r == ces_pkg::S_VFETCH && step_r == 2'h1 && mem_ack;
  endsequence

  status_copy_a: assert property (enter_exc_s |-> sr_copy_r == $past(sr_nxt))
    else $error("status copy not taken on entry");
  super_entry_a: assert property (enter_exc_s |=> sr_r[`CES_SR_S] && !sr_r[`CES_SR_T])
    else $error("handler not privileged or still traced");
  mask_keep_a: assert property (state_r == ces_pkg::S_CAPTURE && !irq_r |=>
    sr_r[`CES_SR_MHI:`CES_SR_MLO] == $past(sr_r[`CES_SR_MHI:`CES_SR_MLO]))
    else $error("mask changed for a non-interrupt exception");
  iack_irq_a: assert property (iack_req |-> irq_r)
    else $error("acknowledge cycle for an internal exception");
  reset_nopush_a: assert property (state_r == ces_pkg::S_RESET_FETCH |-> !mem.we)
    else $error("reset wrote the stack");
  stack_super_a: assert property (mem_req && mem.we |-> sup)
    else $error("frame built outside supervisor state");
  handler_load_a: assert property (last_fetch_s |=>
    state_r == ces_pkg::S_IDLE && pc_r[15:0] == $past(mem_rdata))
    else $error("handler address not loaded");
  vec_addr_a: assert property (state_r == ces_pkg::S_VFETCH && step_r == 2'h0 |->
    mem.addr == {14'h0000, vec_r, 2'b00})
    else $error("vector address wrong");
  user_reset_a: assert property (take && insn.op == ces_pkg::OP_RESET && !sup |=>
    !reset_output_line && state_r == ces_pkg::S_CAPTURE)
    else $error("user reset did not trap");
  user_or_a: assert property (take && insn.op == ces_pkg::OP_ORSR && !sup |=>
    sr_r == $past(sr_r) && pc_r == $past(pc_r))
    else $error("user or-immediate changed state");
  push_step_a: assert property (state_r == ces_pkg::S_STACK && mem_ack |=>
    ssp_r == $past(ssp_r) - `CES_WSTEP)
    else $error("push did not step stack down by two");
  pop_step_a: assert property (state_r == ces_pkg::S_RTE_POP && mem_ack |=>
    ssp_r == $past(ssp_r) + `CES_WSTEP)
    else $error("pop did not step stack up by two");
  halt_load_a: assert property (take && insn.op == ces_pkg::OP_HALT && sup && !sr_r[`CES_SR_T] |=>
    halted && sr_r == ($past(insn.imm) & `CES_SR_IMPL))
    else $error("halt did not load status and stop");
endmodule : ces_seq

// File: ces_partner.sv
// Purpose: memory and interrupting peripheral beside the sequencer
// Assumes: 2 KB of word memory, vector table preloaded
// Notes: slow adds two wait cycles; idle data lines show inverted data
`timescale 1ns/1ps
module ces_partner (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory side
  input wire logic mem_req,
  input wire ces_pkg::ces_mem_t mem,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // acknowledge side
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  output logic iack_ack,
  output logic [7:0] iack_vec,
  // bench control
  input wire logic slow,
  input wire logic [7:0] vec
);
  logic [15:0] ram [0:1023];
  logic [15:0] rd_r;
  logic [2:0] lvl_r;
  logic [1:0] wait_r;
  int n_wr;
  // vector v holds pc v*256; word 1 holds the initial stack top
  initial
  begin
    n_wr = 0;
    for (int v = 0; v < 128; v++)
    begin
      ram[2 * v] = 16'h0000;
      ram[2 * v + 1] = {v[7:0], 8'h00};
    end
    ram[1] = 16'h0800;
  end
  // each request served when it comes, no order assumed
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_ack <= 1'b0;
      iack_ack <= 1'b0;
      wait_r <= 2'h0;
    end
    else if (mem_ack || iack_ack)
    begin
      mem_ack <= 1'b0;
      iack_ack <= 1'b0;
    end
    else if ((mem_req || iack_req) && wait_r < {slow, 1'b0})
      wait_r <= wait_r + 2'h1;
    else if (mem_req)
    begin
      wait_r <= 2'h0;
      mem_ack <= 1'b1;
      rd_r <= ram[mem.addr[10:1]];
      if (mem.we)
      begin
        ram[mem.addr[10:1]] <= mem.wdata;
        n_wr <= n_wr + 1;
      end
    end
    else if (iack_req)
    begin
      wait_r <= 2'h0;
      iack_ack <= 1'b1;
      lvl_r <= iack_level;
    end
  end
  // lines not driven by an answer carry junk, not the old value
  assign mem_rdata = mem_ack ? rd_r : ~rd_r;
  assign iack_vec = iack_ack ? vec : ~vec;
endmodule : ces_partner

// File: cpu_exception_sequencer_test.sv
// Purpose: self-checking bench of the exception sequencer
// Assumes: partner memory answers every request
// Notes: skips pushed pc where the core's choice is open
`timescale 1ns/1ps
`include "ces_params.svh"
module cpu_exception_sequencer_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_level, iack_level;
  logic insn_valid, insn_ready, bus_err, addr_err, iack_req, iack_ack;
  ces_pkg::ces_insn_t insn;
  logic [7:0] iack_vec, vec;
  logic mem_req, mem_ack, reset_output_line, halted, slow;
  ces_pkg::ces_mem_t mem;
  logic [15:0] mem_rdata, status_word;
  logic [31:0] sp, r;
  int fails, n_checks;
  assign hready = hreadyout;
  ces_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .insn_valid(insn_valid), .insn(insn),
    .insn_ready(insn_ready), .bus_err(bus_err), .addr_err(addr_err), .irq_level(irq_level),
    .iack_req(iack_req), .iack_level(iack_level), .iack_ack(iack_ack), .iack_vec(iack_vec),
    .mem_req(mem_req), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .reset_output_line(reset_output_line), .halted(halted), .status_word(status_word));
  ces_partner part (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .iack_req(iack_req), .iack_level(iack_level),
    .iack_ack(iack_ack), .iack_vec(iack_vec), .slow(slow), .vec(vec));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic test_done;
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for a level, sampled mid-cycle, ends on a rising edge
  task automatic wait_for(ref logic s, input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (s !== lvl && n < 3000);
    if (n >= 3000)
      chk(32'h0, 32'h1);
    @(posedge hclk);
  endtask : wait_for
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task automatic issue(input ces_pkg::ces_op_t op, input logic [15:0] imm, input logic fail);
    insn_valid <= 1'b1;
    insn <= '{op, imm, 4'h0, fail, 32'h1230, 32'h1234};
    wait_for(insn_ready, 1'b1);
    insn_valid <= 1'b0;
  endtask : issue
  // frame sits below the old stack top; pcx all ones skips pushed pc
  task automatic exc_chk(input logic [7:0] v, input logic [31:0] pcx, input logic [15:0] sr);
    wait_for(insn_ready, 1'b1);
    ahb(1'b0, `CES_A_PC, 32'h0);
    chk(r, {16'h0, v, 8'h00});
    ahb(1'b0, `CES_A_SSP, 32'h0);
    chk(r, sp - 32'h8);
    chk(part.ram[sp[10:1] - 10'h1], {4'h0, 2'h0, v, 2'h0});
    if (pcx !== 32'hffffffff)
    begin
      chk(part.ram[sp[10:1] - 10'h2], pcx[15:0]);
      chk(part.ram[sp[10:1] - 10'h3], pcx[31:16]);
    end
    chk(part.ram[sp[10:1] - 10'h4], sr);
    chk({status_word[15], status_word[13]}, 2'b01);
  endtask : exc_chk
  task automatic get_sp;
    ahb(1'b0, `CES_A_SSP, 32'h0);
    sp = r;
  endtask : get_sp
  task automatic t_reset;
    chk(status_word, `CES_SR_RST);
    wait_for(insn_ready, 1'b1);
    ahb(1'b0, `CES_A_PC, 32'h0);
    chk(r, 32'h100);
    get_sp();
    chk(sp, 32'h800);
    chk(part.n_wr, 0);
    ahb(1'b0, `CES_A_INFO, 32'h0);
    chk(r, 32'h0);
    chk(hresp, 1'b0);
  endtask : t_reset
  task automatic t_trap_ret;
    // overflow flag set here so the overflow trap below fires
    issue(ces_pkg::OP_ORSR, 16'h0007, 1'b0);
    wait_for(insn_ready, 1'b1);
    chk(status_word, 16'h2707);
    get_sp();
    issue(ces_pkg::OP_TRAP, 16'h0, 1'b0);
    exc_chk(`CES_V_TRAP0, 32'h1234, 16'h2707);
    ahb(1'b1, `CES_A_STATUS, 32'h2300);
    issue(ces_pkg::OP_RTE, 16'h0, 1'b0);
    wait_for(insn_ready, 1'b1);
    chk(status_word, 16'h2707);
    ahb(1'b0, `CES_A_PC, 32'h0);
    chk(r, 32'h1234);
    ahb(1'b0, `CES_A_SSP, 32'h0);
    chk(r, sp);
  endtask : t_trap_ret
  task automatic t_faults;
    ces_pkg::ces_op_t ops[4] = '{ces_pkg::OP_TRAP_ON_OVERFLOW, ces_pkg::OP_CHK, ces_pkg::OP_DIV,
      ces_pkg::OP_ILLEGAL};
    logic [7:0] vs[4] = '{`CES_V_TRAP_ON_OVERFLOW, `CES_V_CHK, `CES_V_DIVZ, `CES_V_ILLEGAL};
    for (int i = 0; i < 4; i++)
    begin
      get_sp();
      issue(ops[i], 16'h0, 1'b1);
      exc_chk(vs[i], 32'hffffffff, 16'h2707);
    end
  endtask : t_faults
  // privileged opcodes in user state must trap with nothing changed
  task automatic t_user;
    ces_pkg::ces_op_t ops[4] = '{ces_pkg::OP_RESET, ces_pkg::OP_ORSR, ces_pkg::OP_HALT,
      ces_pkg::OP_RTE};
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, `CES_A_STATUS, 32'h0);
      get_sp();
      issue(ops[i], 16'hffff, 1'b0);
      exc_chk(`CES_V_PRIV, 32'h1230, 16'h0000);
      chk({reset_output_line, halted}, 2'b00);
    end
  endtask : t_user
  task automatic t_reset_output_line;
    int n;
    n = 0;
    issue(ces_pkg::OP_RESET, 16'h0, 1'b0);
    repeat (100)
    begin
      @(negedge hclk);
      if (reset_output_line === 1'b1)
        n++;
    end
    @(posedge hclk);
    chk(n, `CES_RESET_OUTPUT_LINE_CYCLES);
  endtask : t_reset_output_line
  task automatic t_irq;
    get_sp();
    slow <= 1'b1;
    vec <= 8'h40;
    irq_level <= 3'h3;
    exc_chk(8'h40, 32'hffffffff, 16'h2000);
    chk(part.lvl_r, 3'h3);
    chk(status_word[10:8], 3'h3);
    irq_level <= 3'h0;
    slow <= 1'b0;
  endtask : t_irq
  task automatic t_halt_err;
    issue(ces_pkg::OP_HALT, 16'h2704, 1'b0);
    wait_for(halted, 1'b1);
    chk(status_word, 16'h2704);
    get_sp();
    bus_err <= 1'b1;
    wait_for(halted, 1'b0);
    bus_err <= 1'b0;
    exc_chk(`CES_V_BUSERR, 32'hffffffff, 16'h2704);
    get_sp();
    addr_err <= 1'b1;
    wait_for(mem_req, 1'b1);
    addr_err <= 1'b0;
    exc_chk(`CES_V_ADDRERR, 32'hffffffff, 16'h2704);
  endtask : t_halt_err
  initial
  begin
    {hresetn, hsel, hwrite, insn_valid, bus_err, addr_err, slow} = '0;
    {haddr, hwdata, htrans, irq_level} = '0;
    hsize = 3'h2;
    vec = 8'h0;
    insn = '0;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_trap_ret();
    t_faults();
    t_user();
    t_reset_output_line();
    t_irq();
    t_halt_err();
    test_done();
  end
  // whole run needs a few hundred cycles
  initial
  begin
    #1000000;
    fails++;
    test_done();
  end
endmodule : cpu_exception_sequencer_test
